// >>> verilog/sorx_top.sv
// The implementer's own choices: the plain strobed port and the register offsets.
`timescale 1ns/100ps
`include "sorx_defs.svh"
module sorx_top #(
   parameter int NCH = 4
) (
   // Clock and reset.
   input  wire logic                     clk,
   input  wire logic                     rst,
   // Register port.
   input  wire logic [1:0]               reg_addr,
   input  wire logic [7:0]               reg_wdata,
   input  wire logic                     reg_wr,
   input  wire logic                     reg_rd,
   output logic [7:0]                    reg_rdata,
   // Frame timing from the pointer generator side.
   input  wire logic                     frame_sync,
   // Per-channel stream inputs.
   input  wire logic [NCH-1:0][7:0]      rx_toh_byte,
   input  wire logic [NCH-1:0][7:0]      pg_byte,
   input  wire logic [NCH-1:0]           pg_valid,
   input  wire logic [NCH-1:0]           pg_j1,
   input  wire logic [NCH-1:0]           pg_neg_stuff,
   input  wire logic [NCH-1:0]           lof,
   input  wire logic [NCH-1:0][11:0]     path_ais,
   input  wire logic [NCH-1:0][11:0]     conc_member,
   // Pins.
   input  wire logic                     overhead_serial_clock,
   input  wire logic                     prot_switch_ab,
   input  wire logic                     prot_switch_cd,
   input  wire logic                     lvds_en_pin,
   input  wire logic                     bscan_mode,
   // Parallel outputs.
   output logic [NCH-1:0][7:0]           par_data,
   output logic [NCH-1:0]                payload_flag,
   output logic [NCH-1:0]                trace_pointer_marker,
   output logic [NCH-1:0]                par_oe,
   // Serial overhead outputs.
   output logic [NCH-1:0]                ser_data,
   output logic [NCH-1:0]                ser_oe,
   output logic                          rx_overhead_clock_enable,
   output logic                          rx_overhead_row_pulse,
   // Channel power and buffers.
   output logic [NCH-1:0]                hsi_powerdown,
   output logic [NCH-1:0]                lvds_buf_en
);

   //---------------------------------------------------------------------------
   // Registers
   //---------------------------------------------------------------------------
   logic [7:0] ctrl_r;
   logic [7:0] mode_r;
   logic [7:0] prot_r;
   logic [7:0] rdata_nxt;
   logic [NCH-1:0] lais;
   wire  [NCH-1:0] ch_en     = ctrl_r[`SORX_CTRL_EN_LSB +: NCH];
   wire  [NCH-1:0] k_pass    = ctrl_r[`SORX_CTRL_KPASS_LSB +: NCH];
   wire  [NCH-1:0] ais_force = mode_r[`SORX_MODE_AIS_LSB +: NCH];
   wire  [NCH-1:0] lvds_sw   = mode_r[`SORX_MODE_LVDS_LSB +: NCH];
   wire            redund    = prot_r[`SORX_PROT_REDUND];

   // Read mux: status shows line AIS per channel and powerdown.
   always_comb begin
      unique case (reg_addr)
         `SORX_REG_CTRL: rdata_nxt = ctrl_r;
         `SORX_REG_MODE: rdata_nxt = mode_r;
         `SORX_REG_PROT: rdata_nxt = prot_r;
         `SORX_REG_STAT: rdata_nxt = {hsi_powerdown, lais};
      endcase
   end

   // Register writes; all channels reset disabled.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl_r <= `SORX_CTRL_RST;
         mode_r <= `SORX_MODE_RST;
         prot_r <= `SORX_PROT_RST;
      end else if (reg_wr) begin
         if (reg_addr == `SORX_REG_CTRL) ctrl_r <= reg_wdata;
         if (reg_addr == `SORX_REG_MODE) mode_r <= reg_wdata;
         if (reg_addr == `SORX_REG_PROT) prot_r <= reg_wdata;
      end
   end

   // Read data stands for the one cycle after the strobe.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) reg_rdata <= 8'h00;
      else     reg_rdata <= reg_rd ? rdata_nxt : 8'h00;
   end

   //---------------------------------------------------------------------------
   // Pin synchronisers
   //---------------------------------------------------------------------------
   logic [4:0] pin_s1;
   logic [4:0] pin_s2;
   logic       tck_d;
   wire        tck_rise = pin_s2[0] & ~tck_d;
   wire        hw_ab    = pin_s2[1];
   wire        hw_cd    = pin_s2[2];
   wire        lvds_pin = pin_s2[3];
   wire        bscan    = pin_s2[4];

   // Two flops per pin, then edge detect on the overhead clock pin.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pin_s1 <= 5'h00;
         pin_s2 <= 5'h00;
         tck_d  <= 1'b0;
      end else begin
         pin_s1 <= {bscan_mode, lvds_en_pin, prot_switch_cd, prot_switch_ab, overhead_serial_clock};
         pin_s2 <= pin_s1;
         tck_d  <= pin_s2[0];
      end
   end

   //---------------------------------------------------------------------------
   // Frame position counters
   //---------------------------------------------------------------------------
   logic [10:0] col_r;
   logic [3:0]  row_r;
   logic [3:0]  sts_r;
   wire         col_end = (col_r == `SORX_ROW_LAST);
   wire         in_toh  = (col_r <= `SORX_TOH_LAST);

   // Column, row and STS-1 interleave counters; frame_sync restarts them.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         col_r <= 11'd0;
         row_r <= 4'd0;
         sts_r <= 4'd0;
      end else if (frame_sync) begin
         col_r <= 11'd1;
         row_r <= 4'd0;
         sts_r <= 4'd1;
      end else begin
         col_r <= col_end ? 11'd0 : col_r + 11'd1;
         sts_r <= (col_end || sts_r == `SORX_STS_LAST) ? 4'd0 : sts_r + 4'd1;
         if (col_end) row_r <= (row_r == `SORX_ROWS_LAST) ? 4'd0 : row_r + 4'd1;
      end
   end

   //---------------------------------------------------------------------------
   // Parallel overhead rebuild and payload flags
   //---------------------------------------------------------------------------
   // Builds {payload flag, marker, byte} for one position.
   function automatic logic [9:0] build(
      input logic [10:0] col,
      input logic [3:0]  row,
      input logic [3:0]  sts,
      input logic [7:0]  raw,
      input logic [7:0]  pgb,
      input logic        valid,
      input logic        j1,
      input logic        neg,
      input logic        kp,
      input logic        la,
      input logic [11:0] pais,
      input logic [11:0] conc
   );
      logic [7:0] b;
      logic       spe;
      logic       mk;
      b   = `SORX_ZERO;
      spe = 1'b0;
      mk  = 1'b0;
      if (col > `SORX_TOH_LAST) begin
         b   = pgb;
         spe = valid;
         mk  = valid & j1 & ~pais[sts] & ~conc[sts];
      end else if (row == 4'd0) begin
         if (col < `SORX_A2_COL)      b = `SORX_A1_VAL;
         else if (col < `SORX_J0_COL) b = `SORX_A2_VAL;
         mk = (col == `SORX_J0_COL);
      end else if (row == `SORX_H_ROW) begin
         if (col < `SORX_J0_COL) begin
            b = pgb;
         end else if (neg) begin
            b   = pgb;
            spe = 1'b1;
         end
      end else if (row == `SORX_K_ROW && kp &&
                   (col == `SORX_K1_COL || col == `SORX_K2_COL)) begin
         b = la ? `SORX_ONES : raw;
      end
      return {spe, mk, b};
   endfunction

   genvar c;
   generate
      for (c = 0; c < NCH; c++) begin : g_par
         // Redundancy: A and C ports may carry B and D; hardware pins too.
         localparam int PARTNER = c ^ 1;
         wire        pair_hw = (c < 2) ? hw_ab : hw_cd;
         wire        pair_sw = (c < 2) ? prot_r[`SORX_PROT_PAR_AB] : prot_r[`SORX_PROT_PAR_CD];
         wire        take_p  = redund && (c % 2 == 0) && (pair_sw || pair_hw);
         wire        unused  = redund && (c % 2 == 1);
         wire [9:0]  nxt     = take_p ?
            build(col_r, row_r, sts_r, rx_toh_byte[PARTNER], pg_byte[PARTNER], pg_valid[PARTNER],
                  pg_j1[PARTNER], pg_neg_stuff[PARTNER], k_pass[PARTNER], lais[PARTNER],
                  path_ais[PARTNER], conc_member[PARTNER]) :
            build(col_r, row_r, sts_r, rx_toh_byte[c], pg_byte[c], pg_valid[c], pg_j1[c],
                  pg_neg_stuff[c], k_pass[c], lais[c], path_ais[c], conc_member[c]);
         wire        live    = ch_en[c] && !unused;

         // Registered parallel outputs; a disabled channel shows zeros.
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               par_data[c]             <= 8'h00;
               payload_flag[c]         <= 1'b0;
               trace_pointer_marker[c] <= 1'b0;
               par_oe[c]               <= 1'b0;
               ser_oe[c]               <= 1'b0;
               hsi_powerdown[c]        <= 1'b1;
               lvds_buf_en[c]          <= 1'b0;
               lais[c]                 <= 1'b0;
            end else begin
               par_data[c]             <= live ? nxt[7:0] : 8'h00;
               payload_flag[c]         <= live & nxt[9];
               trace_pointer_marker[c] <= live & nxt[8];
               par_oe[c]               <= live;
               ser_oe[c]               <= live;
               hsi_powerdown[c]        <= ~ch_en[c];
               lvds_buf_en[c]          <= bscan ? lvds_pin : lvds_sw[c];
               lais[c]                 <= lof[c] | ais_force[c];
            end
         end
      end
   endgenerate

   //---------------------------------------------------------------------------
   // Serial overhead capture
   //---------------------------------------------------------------------------
   logic [7:0] cap  [NCH][36];
   logic [7:0] snd  [NCH][36];
   logic       pend_r;
   logic       cap_first_r;
   logic       snd_first_r;
   logic [NCH-1:0] snd_ais_r;
   sorx_pkg::sorx_ser_e st_r;
   logic [8:0] bit_r;
   wire        start = (st_r == sorx_pkg::SORX_IDLE) && tck_rise && pend_r;
   wire        row_done = in_toh && (col_r == `SORX_TOH_LAST);

   // Capture each row's overhead bytes in arrival order per channel.
   always_ff @(posedge clk) begin
      for (int k = 0; k < NCH; k++) begin
         if (in_toh) cap[k][col_r[5:0]] <= rx_toh_byte[k];
         if (start) snd[k] <= cap[k];
      end
   end

   // Row ready flag; a new row wins over the clear on start.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pend_r      <= 1'b0;
         cap_first_r <= 1'b0;
      end else if (row_done) begin
         pend_r      <= 1'b1;
         cap_first_r <= (row_r == 4'd0);
      end else if (start) begin
         pend_r      <= 1'b0;
      end
   end

   //---------------------------------------------------------------------------
   // Serial burst engine on overhead clock rising edges
   //---------------------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_r                     <= sorx_pkg::SORX_IDLE;
         bit_r                    <= 9'd0;
         snd_first_r              <= 1'b0;
         snd_ais_r                <= '0;
         rx_overhead_clock_enable <= 1'b0;
         rx_overhead_row_pulse    <= 1'b0;
      end else if (tck_rise) begin
         unique case (st_r)
            sorx_pkg::SORX_IDLE: begin
               rx_overhead_clock_enable <= 1'b0;
               rx_overhead_row_pulse    <= 1'b0;
               if (pend_r) begin
                  st_r        <= sorx_pkg::SORX_SEND;
                  bit_r       <= 9'd0;
                  snd_first_r <= cap_first_r;
                  snd_ais_r   <= lais;
               end
            end
            sorx_pkg::SORX_SEND: begin
               if (bit_r == `SORX_ROW_BITS) begin
                  st_r                     <= sorx_pkg::SORX_IDLE;
                  rx_overhead_clock_enable <= 1'b0;
                  rx_overhead_row_pulse    <= 1'b0;
               end else begin
                  bit_r                    <= bit_r + 9'd1;
                  rx_overhead_clock_enable <= 1'b1;
                  rx_overhead_row_pulse    <= (bit_r == 9'd0);
               end
            end
         endcase
      end
   end

   //---------------------------------------------------------------------------
   // Serial ports with parity and line AIS
   //---------------------------------------------------------------------------
   wire sending = (st_r == sorx_pkg::SORX_SEND) && (bit_r != `SORX_ROW_BITS);
   wire par_slot = snd_first_r && (bit_r == 9'd0);

   genvar p;
   generate
      for (p = 0; p < NCH; p++) begin : g_ser
         localparam int PARTNER = p ^ 1;
         wire   ser_sel = (p < 2) ? prot_r[`SORX_PROT_SER_AB] : prot_r[`SORX_PROT_SER_CD];
         wire   take_p  = redund && (p % 2 == 0) && ser_sel;
         wire [7:0] byte_sel = take_p ? snd[PARTNER][bit_r[8:3]] : snd[p][bit_r[8:3]];
         wire   ais_sel = take_p ? snd_ais_r[PARTNER] : snd_ais_r[p];
         wire   raw_bit = byte_sel[3'd7 - bit_r[2:0]];
         logic  acc_r;
         wire   out_bit = ais_sel ? 1'b1 :
                          (par_slot ? acc_r : raw_bit);

         // Even parity over every bit sent in the previous overhead frame.
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               acc_r       <= 1'b0;
               ser_data[p] <= 1'b0;
            end else if (tck_rise) begin
               if (sending) begin
                  ser_data[p] <= out_bit;
                  if (par_slot) begin
                     acc_r  <= out_bit;
                  end else begin
                     acc_r  <= acc_r ^ out_bit;
                  end
               end else begin
                  ser_data[p] <= 1'b0;
               end
            end
         end
      end
   endgenerate

endmodule

// >>> verilog/sorx_defs.svh
//------------------------------------------------------------------------------
// Overview of operation
//------------------------------------------------------------------------------
// Overview of operation
// - Four serial overhead ports, shared burst clock enable.
// - Overhead bytes leave in standard STS-12 order.
// - One row per burst, aligned to row pulse.
// - Regenerate A1/A2; other positions output zero.
// - H1/H2 from pointer generator, SS and AIS-P kept.
// - H3 carries stuffed data, otherwise zero.
// - K1/K2 pass or zero; line AIS in pass mode.
// - Serial bytes unchanged, most significant bit first.
// - First A1 MSB replaced by even parity.
// - Line AIS drives every serial bit high.
// - Payload flag and marker encode byte type.
// - Marker at J0 of STS-1 one and J1s.
// - No J1 mark for AIS-P or concatenation members.
// - Payload flag high in H3 on negative stuff.
// - Payload flag low on positive stuff, empty columns.
// - Per-channel enable, powerdown, output enables, start down.
// - Buffer enables by software, pin during boundary scan.
// - Redundancy muxes A/B onto A, C/D onto C.
// - Hardware switch pins steer parallel data only.
// - Row pulse, enable and data launched on clock rise.
`ifndef SORX_DEFS_SVH
`define SORX_DEFS_SVH

// Register indices.
`define SORX_REG_CTRL   2'h0
`define SORX_REG_MODE   2'h1
`define SORX_REG_PROT   2'h2
`define SORX_REG_STAT   2'h3

// Reset values: all channels disabled, so all start in powerdown.
`define SORX_CTRL_RST   8'h00
`define SORX_MODE_RST   8'h00
`define SORX_PROT_RST   8'h00

// Field positions.
`define SORX_CTRL_EN_LSB    0
`define SORX_CTRL_KPASS_LSB 4
`define SORX_MODE_AIS_LSB   0
`define SORX_MODE_LVDS_LSB  4
`define SORX_PROT_REDUND    0
`define SORX_PROT_PAR_AB    1
`define SORX_PROT_PAR_CD    2
`define SORX_PROT_SER_AB    3
`define SORX_PROT_SER_CD    4

// Byte values.
`define SORX_A1_VAL     8'hf6
`define SORX_A2_VAL     8'h28
`define SORX_ZERO       8'h00
`define SORX_ONES       8'hff

// Frame geometry in byte times, rows, STS-1 slots and row bits.
`define SORX_ROW_LAST   11'd1079
`define SORX_ROWS_LAST  4'd8
`define SORX_STS_LAST   4'd11
`define SORX_TOH_LAST   11'd35
`define SORX_A2_COL     11'd12
`define SORX_J0_COL     11'd24
`define SORX_H_ROW      4'd3
`define SORX_K_ROW      4'd4
`define SORX_K1_COL     11'd12
`define SORX_K2_COL     11'd24
`define SORX_ROW_BITS   9'd288

`endif

// >>> verilog/sorx_pkg.sv
package sorx_pkg;
   typedef logic [7:0] sorx_byte_t;
   typedef enum logic [0:0] {
      SORX_IDLE = 1'b0,
      SORX_SEND = 1'b1
   } sorx_ser_e;
endpackage

// >>> verification/sorx_checker.sv
`timescale 1ns/100ps
// Watches the framer ports for timing and format relations.
module sorx_checker #(
   parameter int NCH = 4
) (
   // Clock, reset and register port.
   input wire logic                clk,
   input wire logic                rst,
   input wire logic [1:0]          reg_addr,
   input wire logic                reg_rd,
   input wire logic [7:0]          reg_rdata,
   // Frame timing and parallel side.
   input wire logic                frame_sync,
   input wire logic [NCH-1:0][7:0] par_data,
   input wire logic [NCH-1:0]      payload_flag,
   input wire logic [NCH-1:0]      trace_pointer_marker,
   input wire logic [NCH-1:0]      par_oe,
   // Serial side and power.
   input wire logic [NCH-1:0]      ser_data,
   input wire logic                rx_overhead_clock_enable,
   input wire logic                rx_overhead_row_pulse,
   input wire logic [NCH-1:0]      hsi_powerdown
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   // A powered-down channel must never drive its parallel bus.
   pd_oe_excl_a: assert property ((par_oe & hsi_powerdown) == '0)
      else $error("Output enable on a powered-down channel.");
   stat_pd_match_a: assert property (reg_rd && reg_addr == 2'h3 |=> reg_rdata[7:4] == $past(hsi_powerdown))
      else $error("Status powerdown bits disagree with the powerdown outputs.");
   // Framing bytes and flags at the head of each frame.
   a1_regen_a: assert property (frame_sync ##1 par_oe[0] |-> par_data[0] == 8'hf6)
      else $error("First framing byte not regenerated.");
   a2_regen_a: assert property (frame_sync ##13 par_oe[0] |-> par_data[0] == 8'h28)
      else $error("Second framing byte not regenerated.");
   j0_marker_a: assert property (frame_sync ##25 par_oe[0] |-> trace_pointer_marker[0] && !payload_flag[0])
      else $error("Section trace marker missing.");
   a1_flag_low_a: assert property (frame_sync |=> (payload_flag == '0 && trace_pointer_marker == '0) [*8])
      else $error("Flags raised during framing bytes.");
   // Serial burst framing.
   pulse_has_en_a: assert property (rx_overhead_row_pulse |-> rx_overhead_clock_enable)
      else $error("Row pulse without clock enable.");
   burst_head_a: assert property ($rose(rx_overhead_clock_enable) |-> rx_overhead_row_pulse)
      else $error("Burst started without a row pulse.");
   ser_idle_low_a: assert property (!rx_overhead_clock_enable |-> ser_data == '0)
      else $error("Serial data active outside a burst.");

   // Main scenarios reached.
   cover property (frame_sync ##25 trace_pointer_marker[0]);
   cover property ($rose(rx_overhead_row_pulse));
   cover property (reg_rd && reg_addr == 2'h3);
endmodule

bind sorx_top sorx_checker #(.NCH(NCH)) u_chk (
   .clk, .rst, .reg_addr, .reg_rd, .reg_rdata, .frame_sync, .par_data, .payload_flag,
   .trace_pointer_marker, .par_oe, .ser_data, .rx_overhead_clock_enable,
   .rx_overhead_row_pulse, .hsi_powerdown
);

// >>> verification/sorx_fabric_model.sv
`timescale 1ns/100ps
// Fabric side: overhead clock and serial capture.
module sorx_fabric_model (
   // Overhead clock towards the device.
   output logic       overhead_serial_clock,
   // Serial overhead side.
   input wire logic [3:0] ser_data,
   input wire logic       rx_overhead_clock_enable,
   input wire logic       rx_overhead_row_pulse,
   // Parallel side.
   input wire logic       clk,
   input wire logic [3:0] payload_flag
);
   logic [0:287] cap [4];
   logic [0:287] last [4];
   logic         busy = 1'b0;
   int           idx = 0;
   int           len = 0;
   int           done = 0;
   int           taken = 0;

   // Free-running clock with an unrelated phase.
   initial begin
      overhead_serial_clock = 1'b0;
      #3.3;
      forever #40 overhead_serial_clock = ~overhead_serial_clock;
   end
   // Sample mid-bit; a row ends on enable low or a new pulse.
   always @(negedge overhead_serial_clock) begin
      if (busy && (rx_overhead_row_pulse || !rx_overhead_clock_enable)) begin
         busy = 1'b0;
         last = cap;
         len = idx;
         done++;
      end
      if (rx_overhead_row_pulse) begin
         busy = 1'b1;
         idx = 0;
      end
      if (busy && rx_overhead_clock_enable && idx < 288) begin
         for (int c = 0; c < 4; c++) cap[c][idx] = ser_data[c];
         idx++;
      end
   end
   // Data is taken only while channel 0's payload flag is high.
   always @(posedge clk) begin
      if (payload_flag[0]) taken++;
   end
endmodule

// >>> verification/tb_top.sv
`timescale 1ns/100ps
// Self-checking bench.
module tb_top;
   logic clk, rst, ovh_clk, ck_en, row_pulse, chk = 1'b0, p_mask;
   logic frame_sync = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, pin_ab = 1'b0, lvds_pin = 1'b1, bscan = 1'b0;
   logic [1:0] reg_addr = '0;
   logic [7:0] reg_wdata = '0, reg_rdata;
   logic [3:0][7:0] toh = '0, pg = '0, par_data, p_pg;
   logic [3:0] valid = '0, j1 = '0, neg = '0, flag, mark, par_oe, ser_data, ser_oe, pdn, lvds_en;
   logic [3:0] en = '0, p_val, p_j1, p_neg;
   logic [3:0][11:0] pais = '0, conc = '0;
   logic kp = 1'b0, red = 1'b0, par_ab = 1'b0, par_cd = 1'b0, mask_ais = 1'b0, mask_conc = 1'b0;
   logic [31:0] seed = 32'h0000002b;
   int col = 0, row = 0, p_col, p_row, fail_count = 0, comparisons = 0;

   sorx_top #(.NCH(4)) u_sorx_top (
      .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .frame_sync(frame_sync), .rx_toh_byte(toh),
      .pg_byte(pg), .pg_valid(valid), .pg_j1(j1), .pg_neg_stuff(neg), .lof(4'h0),
      .path_ais(pais), .conc_member(conc), .overhead_serial_clock(ovh_clk), .prot_switch_ab(pin_ab),
      .prot_switch_cd(1'b0), .lvds_en_pin(lvds_pin), .bscan_mode(bscan), .par_data(par_data),
      .payload_flag(flag), .trace_pointer_marker(mark), .par_oe(par_oe), .ser_data(ser_data),
      .ser_oe(ser_oe), .rx_overhead_clock_enable(ck_en), .rx_overhead_row_pulse(row_pulse),
      .hsi_powerdown(pdn), .lvds_buf_en(lvds_en)
   );
   sorx_fabric_model u_fab (
      .overhead_serial_clock(ovh_clk), .ser_data(ser_data), .rx_overhead_clock_enable(ck_en),
      .rx_overhead_row_pulse(row_pulse), .clk(clk), .payload_flag(flag)
   );

   // Overhead byte per column and channel.
   function automatic logic [7:0] toh_val(input int c, input int ch);
      return 8'(c * 29 + ch * 64 + 3);
   endfunction
   // Xorshift source.
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %0t %s: seen %h expected %h", $time, what, seen, exp);
      end
   endtask
   task automatic conclude();
      if (fail_count == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // Drive the stream inputs.
   always @(posedge clk) begin
      logic [31:0] r;
      int nc, nr;
      p_col = col;
      p_row = row;
      p_pg = pg;
      p_val = valid;
      p_j1 = j1;
      p_neg = neg;
      p_mask = |{pais, conc};
      nc = (col == 1079) ? 0 : col + 1;
      nr = (col != 1079) ? row : (row == 8) ? 0 : row + 1;
      col <= nc;
      row <= nr;
      frame_sync <= (nc == 0 && nr == 0);
      pais <= {4{mask_ais ? 12'hfff : 12'h000}};
      conc <= {4{mask_conc ? 12'hfff : 12'h000}};
      for (int c = 0; c < 4; c++) begin
         r = rnd();
         toh[c] <= toh_val(nc, c);
         pg[c] <= r[7:0];
         valid[c] <= r[8] | r[12];
         j1[c] <= (r[8] | r[12]) && r[11:9] == 3'h0 && nc >= 36;
         if (nc == 0 && nr == 0) neg[c] <= r[13];
      end
   end
   // Model of the parallel outputs, one cycle late.
   always @(negedge clk) begin
      logic [7:0] d;
      logic f, m, o, c;
      int s;
      for (int p = 0; p < 4 && chk; p++) begin
         s = (red && p == 0 && (par_ab || pin_ab)) ? 1 : (red && p == 2 && par_cd) ? 3 : p;
         o = en[p] && !(red && p[0]);
         d = 8'h00;
         f = 1'b0;
         m = 1'b0;
         c = !p_mask;
         if (o && p_col >= 36) begin
            f = p_val[s];
            m = p_j1[s] && !p_mask;
            c = c && f;
            d = p_pg[s];
         end else if (o && p_row == 0) begin
            d = (p_col < 12) ? 8'hf6 : (p_col < 24) ? 8'h28 : 8'h00;
            m = (p_col == 24);
         end else if (o && p_row == 3) begin
            f = (p_col >= 24) && p_neg[s];
            d = (p_col < 24 || f) ? p_pg[s] : 8'h00;
         end else if (o && p_row == 4 && (p_col == 12 || p_col == 24) && kp) begin
            d = toh_val(p_col, s);
         end
         check(16'({par_oe[p], ser_oe[p]}), 16'({o, o}), "output enable");
         check(16'(flag[p]), 16'(f), "payload flag");
         check(16'(mark[p]), 16'(m), "trace marker");
         if (c) check(16'(par_data[p]), 16'(d), "parallel byte");
      end
   end

   task automatic wr(input logic [1:0] a, input logic [7:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   // Read data stands only in the cycle after the strobe.
   task automatic rd(input logic [1:0] a, input logic [7:0] e);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      check(16'(reg_rdata), 16'(e), "register read");
   endtask
   // Write a register, then let it settle.
   task automatic setreg(input logic [1:0] a, input logic [7:0] v);
      chk = 1'b0;
      wr(a, v);
      if (a == 2'h0) begin
         en = v[3:0];
         kp = v[4];
      end
      if (a == 2'h2) begin
         red = v[0];
         par_ab = v[1];
         par_cd = v[2];
      end
      repeat (8) @(posedge clk);
      chk = 1'b1;
   endtask
   // Wait for three fresh bursts.
   task automatic grab();
      int s, n;
      s = u_fab.done;
      n = 0;
      while (u_fab.done < s + 3 && n < 15000) begin
         @(posedge clk);
         n++;
      end
      check(16'(n < 15000), 16'h0001, "burst wait");
      check(16'(u_fab.len), 16'h0120, "burst length");
   endtask
   task automatic ser_cmp(input int port, input int src, input logic ais);
      logic [7:0] b;
      for (int k = 1; k < 288; k++) begin
         b = toh_val(k / 8, src);
         check(16'(u_fab.last[port][k]), ais ? 16'h0001 : 16'(b[7 - k % 8]), "serial bit");
      end
      if (ais) check(16'(u_fab.last[port][0]), 16'h0001, "parity bit");
   endtask

   initial begin
      rst = 1'b1;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      check(16'({pdn, par_oe, ser_oe}), 16'h0f00, "reset outputs");
      rd(2'h0, 8'h00);
      rd(2'h1, 8'h00);
      rd(2'h2, 8'h00);
      wr(2'h3, 8'haa);
      rd(2'h3, 8'hf0);
      while (!frame_sync) @(posedge clk);
      setreg(2'h0, 8'hff);
      repeat (9720) @(posedge clk);
      rd(2'h3, 8'h00);
      mask_ais <= 1'b1;
      repeat (5000) @(posedge clk);
      mask_ais <= 1'b0;
      mask_conc <= 1'b1;
      repeat (5000) @(posedge clk);
      mask_conc <= 1'b0;
      setreg(2'h0, 8'h07);
      repeat (3000) @(posedge clk);
      check(16'(pdn), 16'h0008, "powerdown");
      rd(2'h3, 8'h80);
      setreg(2'h0, 8'h0f);
      grab();
      for (int c = 0; c < 4; c++) begin
         ser_cmp(c, c, 1'b0);
      end
      setreg(2'h1, 8'h01);
      grab();
      ser_cmp(0, 0, 1'b1);
      ser_cmp(1, 1, 1'b0);
      rd(2'h3, 8'h01);
      setreg(2'h1, 8'h00);
      // Redundancy by pin, then by register.
      for (int k = 0; k < 2; k++) begin
         pin_ab <= (k == 0);
         setreg(2'h2, k == 0 ? 8'h11 : 8'h05);
         grab();
         ser_cmp(0, 0, 1'b0);
         ser_cmp(2, k == 0 ? 3 : 2, 1'b0);
      end
      pin_ab <= 1'b0;
      setreg(2'h2, 8'h00);
      // Buffer enables: software, then scan pin.
      for (int k = 0; k < 3; k++) begin
         bscan <= (k != 0);
         lvds_pin <= (k == 1);
         wr(2'h1, 8'ha0);
         repeat (6) @(posedge clk);
         @(negedge clk);
         check(16'(lvds_en), k == 0 ? 16'h000a : k == 1 ? 16'h000f : 16'h0000, "buffer enable");
      end
      conclude();
   end
   // Cut a hung run short.
   initial begin
      #780000;
      fail_count++;
      conclude();
   end
endmodule
